/* msi_pkg.sv */
// Types, constants and helper functions for the multimode serial channel
// Contract
// - 7/8/9 data, optional parity, 1 or 2 stops
// - Receiver flags parity, overrun and framing errors
// - LSB/MSB order selectable; I2C is MSB only
// - Transmit buffer separate from transmit shifter
// - Received word moves into separate receive buffer
// - Empty, end, full, error, I2C condition events
// - Bit timing from programmable baud generator
// - Smartcard mode as asynchronous variant
// - Simple single-master I2C and simple SPI modes
`default_nettype none
package msi_pkg;
  localparam logic [3:0] PH_MID   = 4'h7;
  localparam logic [3:0] PH_HIGH  = 4'h8;
  localparam logic [3:0] PH_SAMP  = 4'hB;
  localparam logic [3:0] PH_LAST  = 4'hF;
  localparam logic [3:0] MAX_BITS = 4'h9;
  localparam logic       LINE_IDLE = 1'b1;
  localparam logic [1:0] LEN_7    = 2'h0;
  localparam logic [1:0] LEN_8    = 2'h1;
  localparam logic [1:0] LEN_9    = 2'h2;

  typedef enum logic [1:0] {
    MODE_ASYNC = 2'h0, MODE_SMART = 2'h1, MODE_I2C = 2'h2, MODE_SPI = 2'h3
  } msi_mode_t;

  typedef enum logic [1:0] {
    COND_START = 2'h0, COND_RESTART = 2'h1, COND_STOP = 2'h2
  } msi_cond_t;

  typedef enum logic [5:0] {
    TX_IDLE = 6'h01, TX_START = 6'h02, TX_DATA = 6'h04,
    TX_PAR  = 6'h08, TX_STOP  = 6'h10, TX_COND = 6'h20
  } msi_tx_st_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
  } msi_rx_st_t;

  typedef struct packed {
    msi_mode_t  mode;
    logic [1:0] len;
    logic       par_en;
    logic       par_odd;
    logic       stop2;
    logic       msb_first;
  } msi_cfg_t;

  typedef struct packed {
    logic parity;
    logic overrun;
    logic framing;
  } msi_err_t;

  typedef struct packed {
    logic tx_empty;
    logic tx_end;
    logic rx_full;
    logic rx_err;
    logic i2c_start;
    logic i2c_restart;
    logic i2c_stop;
  } msi_irq_t;

  // Mode-dependent format overrides
  function automatic msi_cfg_t msi_eff(msi_cfg_t c);
    msi_cfg_t r;
    r = c;
    case (c.mode)
      MODE_SMART: begin
        r.len    = LEN_8;
        r.par_en = 1'b1;
        r.stop2  = 1'b1;
      end
      MODE_I2C: begin
        r.len       = LEN_8;
        r.par_en    = 1'b0;
        r.msb_first = 1'b1;
      end
      MODE_SPI: begin
        r.len    = LEN_8;
        r.par_en = 1'b0;
      end
      default: begin
        if (c.len == 2'h3) r.len = LEN_8;
      end
    endcase
    return r;
  endfunction

  function automatic logic [3:0] msi_nbits(logic [1:0] len);
    case (len)
      LEN_7:   return 4'h7;
      LEN_9:   return 4'h9;
      default: return 4'h8;
    endcase
  endfunction

  // Puts the n data bits into line order, first bit in bit 0
  function automatic logic [8:0] msi_order(logic [8:0] d, logic [3:0] n, logic msb);
    logic [8:0] r;
    r = d;
    for (int i = 0; i < 9; i++) begin
      if (msb && i < int'(n)) r[i] = d[int'(n) - 1 - i];
    end
    return r;
  endfunction

  function automatic logic msi_par(logic [8:0] d, logic [3:0] n, logic odd);
    logic r;
    r = odd;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(n)) r = r ^ d[i];
    end
    return r;
  endfunction
endpackage
`default_nettype wire

/* msi_buf2.sv */
// Two-entry valid/ready buffer holding received words
`default_nettype none
module msi_buf2 import msi_pkg::*; #(
  parameter int unsigned W = 9
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  if (W < 1) begin : g_chk
    $error("W must be at least 1");
  end

  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic         wp_q, wp_d, rp_q, rp_d;
  logic [1:0]   cnt_q, cnt_d;
  logic         wr, rd;

  assign in_ready  = cnt_q != 2'h2;
  assign out_valid = cnt_q != 2'h0;
  assign out_data  = mem_q[rp_q];
  assign wr        = in_valid && in_ready;
  assign rd        = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    if (wr) begin
      mem_d[wp_q] = in_data;
      wp_d        = !wp_q;
    end
    if (rd) rp_d = !rp_q;
    cnt_d = cnt_q + {1'b0, wr} - {1'b0, rd};
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  buf_bound_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (cnt_q == 2'h2 && !rd) |=> !in_ready) else $error("buffer took a third word");
endmodule
`default_nettype wire

/* msi_serial.sv */
// Multimode serial channel: asynchronous, smartcard, simple I2C and simple SPI
`default_nettype none
module msi_serial import msi_pkg::*; #(
  parameter int unsigned BRG_W = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // Configuration
  input  wire msi_cfg_t         cfg,
  input  wire logic [BRG_W-1:0] brg_div,
  // Transmit data
  input  wire logic             tx_valid,
  output logic                  tx_ready,
  input  wire logic [8:0]       tx_data,
  // Receive data
  output logic                  rx_valid,
  input  wire logic             rx_ready,
  output logic [8:0]            rx_data,
  // Error flags
  output var msi_err_t          err,
  input  wire msi_err_t         err_clr,
  // I2C condition requests
  input  wire logic             cond_req,
  input  wire msi_cond_t        cond_kind,
  output logic                  cond_ready,
  // Events
  output var msi_irq_t          irq,
  // Line pins
  output logic                  txd,
  input  wire logic             rxd,
  output logic                  sck,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe,
  output logic                  scl_o,
  output logic                  scl_oe
);
  if (BRG_W < 2 || BRG_W > 24) begin : g_chk
    $error("BRG_W out of range");
  end

  msi_cfg_t ec;
  logic [3:0] nb, nsh;
  logic i2c, spi, sync;
  assign ec   = msi_eff(cfg);
  assign nb   = msi_nbits(ec.len);
  assign i2c  = ec.mode == MODE_I2C;
  assign spi  = ec.mode == MODE_SPI;
  assign sync = i2c || spi;
  assign nsh  = nb + {3'h0, i2c};

  ////////////////////////////////////////////////////////////////////////////////
  // Baud generator and input synchronisers
  logic [BRG_W-1:0] brg_q, brg_d;
  logic tick_q, tick_d;
  logic [2:0] rs_q, rs_d, ss_q, ss_d;
  logic rxf_q, rxf_d, sdaf_q, sdaf_d, samp;

  always_comb begin
    brg_d  = brg_q - BRG_W'(1);
    tick_d = 1'b0;
    if (brg_q == '0) begin
      brg_d  = brg_div;
      tick_d = 1'b1;
    end
    rs_d   = {rs_q[1:0], rxd};
    ss_d   = {ss_q[1:0], sda_i};
    rxf_d  = (rs_q[2] == rs_q[1]) ? rs_q[2] : rxf_q;
    sdaf_d = (ss_q[2] == ss_q[1]) ? ss_q[2] : sdaf_q;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      brg_q  <= '0;
      tick_q <= 1'b0;
      rs_q   <= 3'h7;
      ss_q   <= 3'h7;
      rxf_q  <= LINE_IDLE;
      sdaf_q <= 1'b1;
    end else begin
      brg_q  <= brg_d;
      tick_q <= tick_d;
      rs_q   <= rs_d;
      ss_q   <= ss_d;
      rxf_q  <= rxf_d;
      sdaf_q <= sdaf_d;
    end
  end
  assign samp = i2c ? sdaf_q : rxf_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Transmitter, also drives the sync-mode clock and I2C conditions
  msi_tx_st_t tx_st_q, tx_st_d;
  logic [3:0] tx_ph_q, tx_ph_d, tx_bit_q, tx_bit_d;
  logic [8:0] tx_sh_q, tx_sh_d, tx_buf_q, tx_buf_d;
  logic tx_par_q, tx_par_d, tx_full_q, tx_full_d, held_q, held_d;
  msi_cond_t cond_q, cond_d;
  logic [2:0] cev_q, cev_d;
  logic txd_q, txd_d, sck_q, sck_d, sda_oe_q, sda_oe_d, scl_oe_q, scl_oe_d;
  logic bit_end, sync_end;

  assign bit_end  = tick_q && tx_ph_q == PH_LAST;
  assign sync_end = sync && tx_st_q == TX_DATA && bit_end && tx_bit_q == nsh - 4'h1;

  always_comb begin
    tx_st_d   = tx_st_q;
    tx_ph_d   = tx_ph_q;
    tx_bit_d  = tx_bit_q;
    tx_sh_d   = tx_sh_q;
    tx_par_d  = tx_par_q;
    tx_buf_d  = tx_buf_q;
    tx_full_d = tx_full_q;
    cond_d    = cond_q;
    held_d    = held_q;
    cev_d     = 3'h0;
    if (tx_valid && !tx_full_q) begin
      tx_buf_d  = tx_data;
      tx_full_d = 1'b1;
    end
    if (tick_q && tx_st_q != TX_IDLE) tx_ph_d = tx_ph_q + 4'h1;
    case (tx_st_q)
      TX_IDLE: begin
        tx_ph_d  = 4'h0;
        tx_bit_d = 4'h0;
        if (cond_req && i2c) begin
          cond_d  = cond_kind;
          tx_st_d = TX_COND;
        end else if (tx_full_q) begin
          tx_full_d = 1'b0;
          tx_sh_d   = msi_order(i2c ? {1'b1, tx_buf_q[7:0]} : tx_buf_q, nb,
                                ec.msb_first);
          tx_par_d  = msi_par(tx_buf_q, nb, ec.par_odd);
          tx_st_d   = sync ? TX_DATA : TX_START;
        end
      end
      TX_START: if (bit_end) tx_st_d = TX_DATA;
      TX_DATA: if (bit_end) begin
        tx_sh_d  = tx_sh_q >> 1;
        tx_bit_d = tx_bit_q + 4'h1;
        if (tx_bit_q == nsh - 4'h1) begin
          tx_bit_d = 4'h0;
          tx_st_d  = sync ? TX_IDLE : (ec.par_en ? TX_PAR : TX_STOP);
        end
      end
      TX_PAR: if (bit_end) tx_st_d = TX_STOP;
      TX_STOP: if (bit_end) begin
        tx_bit_d = tx_bit_q + 4'h1;
        if (tx_bit_q == {3'h0, ec.stop2}) tx_st_d = TX_IDLE;
      end
      TX_COND: if (bit_end) begin
        tx_st_d = TX_IDLE;
        held_d  = cond_q != COND_STOP;
        case (cond_q)
          COND_START:   cev_d = 3'h4;
          COND_RESTART: cev_d = 3'h2;
          default:      cev_d = 3'h1;
        endcase
      end
      default: tx_st_d = TX_IDLE;
    endcase
    if (!i2c) held_d = 1'b0;
    // Pin levels follow the next state so they line up with the registered state
    txd_d    = LINE_IDLE;
    sck_d    = 1'b0;
    sda_oe_d = 1'b0;
    scl_oe_d = held_d;
    case (tx_st_d)
      TX_START: txd_d = 1'b0;
      TX_DATA: begin
        txd_d    = tx_sh_d[0];
        sck_d    = spi && tx_ph_d >= PH_HIGH;
        sda_oe_d = i2c && !tx_sh_d[0];
        scl_oe_d = i2c && tx_ph_d < PH_HIGH;
      end
      TX_PAR: txd_d = tx_par_d;
      TX_COND: begin
        scl_oe_d = 1'b0;
        sda_oe_d = (tx_ph_d < PH_HIGH) == (cond_d == COND_STOP);
      end
      default: ;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tx_st_q   <= TX_IDLE;
      tx_ph_q   <= 4'h0;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 9'h1FF;
      tx_buf_q  <= 9'h000;
      tx_par_q  <= 1'b0;
      tx_full_q <= 1'b0;
      cond_q    <= COND_START;
      held_q    <= 1'b0;
      cev_q     <= 3'h0;
      txd_q     <= LINE_IDLE;
      sck_q     <= 1'b0;
      sda_oe_q  <= 1'b0;
      scl_oe_q  <= 1'b0;
    end else begin
      tx_st_q   <= tx_st_d;
      tx_ph_q   <= tx_ph_d;
      tx_bit_q  <= tx_bit_d;
      tx_sh_q   <= tx_sh_d;
      tx_buf_q  <= tx_buf_d;
      tx_par_q  <= tx_par_d;
      tx_full_q <= tx_full_d;
      cond_q    <= cond_d;
      held_q    <= held_d;
      cev_q     <= cev_d;
      txd_q     <= txd_d;
      sck_q     <= sck_d;
      sda_oe_q  <= sda_oe_d;
      scl_oe_q  <= scl_oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver; sync modes sample in the high half of the transmit bit
  msi_rx_st_t rx_st_q, rx_st_d;
  logic [3:0] rx_ph_q, rx_ph_d, rx_bit_q, rx_bit_d;
  logic [8:0] rx_sh_q, rx_sh_d, word_q, word_d, rx_al;
  logic push_q, push_d, mid, rend, b_ready;
  msi_err_t err_q, err_d;

  assign rx_al = rx_sh_q >> (MAX_BITS - nsh);
  assign mid   = tick_q && rx_ph_q == PH_MID;
  assign rend  = tick_q && rx_ph_q == PH_LAST;

  always_comb begin
    rx_st_d  = rx_st_q;
    rx_ph_d  = rx_ph_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d  = rx_sh_q;
    word_d   = word_q;
    push_d   = 1'b0;
    err_d    = err_q & ~err_clr;
    if (tick_q && rx_st_q != RX_IDLE) rx_ph_d = rx_ph_q + 4'h1;
    case (rx_st_q)
      RX_IDLE: begin
        rx_ph_d  = 4'h0;
        rx_bit_d = 4'h0;
        if (!sync && !rxf_q) rx_st_d = RX_START;
      end
      RX_START: begin
        if (mid && rxf_q) rx_st_d = RX_IDLE;
        else if (rend) rx_st_d = RX_DATA;
      end
      RX_DATA: begin
        if (mid) rx_sh_d = {rxf_q, rx_sh_q[8:1]};
        if (rend) begin
          rx_bit_d = rx_bit_q + 4'h1;
          if (rx_bit_q == nb - 4'h1) rx_st_d = ec.par_en ? RX_PAR : RX_STOP;
        end
      end
      RX_PAR: begin
        if (mid && rxf_q != msi_par(rx_al, nb, ec.par_odd)) err_d.parity = 1'b1;
        if (rend) rx_st_d = RX_STOP;
      end
      RX_STOP: if (mid) begin
        if (!rxf_q) err_d.framing = 1'b1;
        push_d  = 1'b1;
        word_d  = msi_order(rx_al, nb, ec.msb_first);
        rx_st_d = RX_IDLE;
      end
      default: rx_st_d = RX_IDLE;
    endcase
    if (sync && tx_st_q == TX_DATA && tick_q && tx_ph_q == PH_SAMP) begin
      rx_sh_d = {samp, rx_sh_q[8:1]};
    end
    if (sync_end) begin
      push_d = 1'b1;
      word_d = msi_order(rx_al, nb, ec.msb_first);
    end
    // A new word with both buffer entries still unread is lost
    if (push_q && !b_ready) err_d.overrun = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rx_st_q  <= RX_IDLE;
      rx_ph_q  <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q  <= 9'h000;
      word_q   <= 9'h000;
      push_q   <= 1'b0;
      err_q    <= '0;
    end else begin
      rx_st_q  <= rx_st_d;
      rx_ph_q  <= rx_ph_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q  <= rx_sh_d;
      word_q   <= word_d;
      push_q   <= push_d;
      err_q    <= err_d;
    end
  end

  msi_buf2 #(.W(9)) u_rxbuf (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (push_q),
    .in_ready  (b_ready),
    .in_data   (word_q),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign tx_ready   = !tx_full_q;
  assign cond_ready = i2c && tx_st_q == TX_IDLE;
  assign err        = err_q;
  assign irq        = {!tx_full_q, tx_st_q == TX_IDLE && !tx_full_q, rx_valid,
                       |err_q, cev_q};
  assign txd        = txd_q;
  assign sck        = sck_q;
  assign sda_o      = 1'b0;
  assign sda_oe     = sda_oe_q;
  assign scl_o      = 1'b0;
  assign scl_oe     = scl_oe_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence load_s;
    tx_st_q == TX_IDLE && tx_full_q && !(cond_req && i2c);
  endsequence
  sequence cond_end_s;
    tx_st_q == TX_COND && bit_end;
  endsequence

  start_low_a: assert property (tx_st_q == TX_START |-> !txd_q)
    else $error("start bit not low");
  idle_high_a: assert property ((tx_st_q == TX_IDLE && !sync) |-> txd_q)
    else $error("idle line not high");
  stop_len_a: assert property (tx_st_q == TX_STOP |-> txd_q && tx_bit_q <= {3'h0, ec.stop2})
    else $error("stop bits wrong");
  par_bit_a: assert property (tx_st_q == TX_PAR |-> ec.par_en && txd_q == tx_par_q)
    else $error("parity bit wrong");
  i2c_msb_a: assert property ((load_s ##0 i2c) |=> tx_sh_q[0] == $past(tx_buf_q[7]))
    else $error("I2C byte not MSB first");
  tx_hold_a: assert property ((tx_valid && tx_ready) |=> tx_full_q && !tx_ready)
    else $error("transmit buffer not filled");
  overrun_a: assert property ((push_q && !b_ready) |=> err_q.overrun)
    else $error("overrun not flagged");
  framing_a: assert property ((rx_st_q == RX_STOP && mid && !rxf_q) |=> err_q.framing && push_q)
    else $error("framing error not flagged");
  rx_move_a: assert property ((push_q && b_ready) |=> rx_valid)
    else $error("received word not buffered");
  cond_stop_a: assert property ((cond_end_s ##0 cond_q == COND_STOP) |=> irq.i2c_stop && !scl_oe)
    else $error("stop condition event missing");
  brg_tick_a: assert property ((brg_q != '0) |=> !tick_q)
    else $error("baud tick off its count");
endmodule
`default_nettype wire

/* msi_remote.sv */
// Remote asynchronous serial device model for the serial channel bench
`default_nettype none
module msi_remote (
  // Clock
  input  wire logic       mclk,
  // Line pins and frame shape
  input  wire logic       line_in,
  output logic            line_out,
  input  wire logic [7:0] bit_cyc,
  input  wire logic [3:0] n_after
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [12:0] got_q[$];
  logic [12:0] w;
  initial line_out = 1'b1;
  // Samples at bit middles; only the falling start edge re-arms it
  initial begin
    forever begin
      @(negedge line_in);
      repeat (bit_cyc / 2) @(posedge mclk);
      w = '0;
      for (int i = 0; i < n_after; i++) begin
        repeat (bit_cyc) @(posedge mclk);
        w[i] = line_in;
      end
      got_q.push_back(w);
    end
  end
  // Start bit, then n bits with the first bit in bit 0
  task automatic send(input logic [12:0] b, input int n);
    @(posedge mclk);
    line_out <= 1'b0;
    repeat (bit_cyc) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      line_out <= b[i];
      repeat (bit_cyc) @(posedge mclk);
    end
    line_out <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* msi_serial_bench.sv */
// Self-checking bench for the multimode serial channel
`default_nettype none
module msi_serial_bench import msi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk, reset_n, tx_valid, tx_ready, rx_valid, rx_ready;
  logic       cond_req, cond_ready, txd, rxd, sck, sda_o, sda_oe, scl_o, scl_oe;
  logic [15:0] brg_div;
  logic [8:0] tx_data, rx_data;
  logic [7:0] bit_cyc;
  logic [3:0] n_after;
  msi_cfg_t   cfg;
  msi_err_t   err, err_clr;
  msi_cond_t  cond_kind;
  msi_irq_t   irq;
  wire logic  sda_i;
  int         fail_count, num_checks;
  // Pull-up on the data line: low only while someone pulls it
  assign sda_i = ~sda_oe;
  assign bit_cyc = {brg_div[3:0], 4'h0} + 8'h10;
  msi_serial #(.BRG_W(16)) dut (.mclk(mclk), .reset_n(reset_n), .cfg(cfg), .brg_div(brg_div),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .err(err), .err_clr(err_clr),
    .cond_req(cond_req), .cond_kind(cond_kind), .cond_ready(cond_ready), .irq(irq),
    .txd(txd), .rxd(rxd), .sck(sck), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .scl_o(scl_o), .scl_oe(scl_oe));
  msi_remote rem (.mclk(mclk), .line_in(txd), .line_out(rxd), .bit_cyc(bit_cyc),
    .n_after(n_after));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [12:0] e, input logic [12:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Bits after the start bit in line order; k returns their count
  function automatic logic [12:0] frame(input logic [8:0] d, input msi_cfg_t c,
      input logic bad_p, input logic bad_s, output int k);
    int n;
    logic p;
    logic [12:0] f;
    n = (c.mode != MODE_ASYNC) ? 8 : (c.len == LEN_7) ? 7 : (c.len == LEN_9) ? 9 : 8;
    p = c.par_odd ^ bad_p;
    f = '0;
    for (int i = 0; i < n; i++) begin
      f[i] = c.msb_first ? d[n - 1 - i] : d[i];
      p = p ^ d[i];
    end
    k = n;
    if (c.par_en || c.mode == MODE_SMART) begin
      f[k] = p;
      k++;
    end
    f[k] = ~bad_s;
    k++;
    if (c.stop2 || c.mode == MODE_SMART) begin
      f[k] = 1'b1;
      k++;
    end
    return f;
  endfunction
  task automatic put(input logic [8:0] d);
    int t;
    @(negedge mclk);
    tx_valid = 1'b1;
    tx_data = d;
    t = 0;
    while (tx_ready !== 1'b1 && t < 3000) begin
      @(negedge mclk);
      t++;
    end
    chk_bit("tx ready", 1'b1, tx_ready);
    @(negedge mclk);
    tx_valid = 1'b0;
  endtask
  task automatic wait_q(input int n);
    int t;
    t = 0;
    while (rem.got_q.size() < n && t < 3000) begin
      @(negedge mclk);
      t++;
    end
  endtask
  task automatic take(input logic [8:0] e);
    int t;
    // Align to the falling edge so the ready pulse spans exactly one rising edge
    @(negedge mclk);
    t = 0;
    while (rx_valid !== 1'b1 && t < 3000) begin
      @(negedge mclk);
      t++;
    end
    chk_bit("rx full", 1'b1, irq.rx_full);
    chk_word("rx data", {5'h00, e[7:0]}, {5'h00, rx_data[7:0]});
    rx_ready = 1'b1;
    @(negedge mclk);
    rx_ready = 1'b0;
  endtask
  task automatic clr_err;
    @(negedge mclk);
    err_clr = '1;
    @(negedge mclk);
    err_clr = '0;
    chk_word("err clear", 13'h0000, {10'h000, err});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    @(negedge mclk);
    chk_bit("txd idle", 1'b1, txd);
    chk_bit("sck idle", 1'b0, sck);
    chk_bit("rx valid", 1'b0, rx_valid);
    chk_word("reset irq", 13'h0060, {6'h00, irq});
  endtask
  task automatic t_tx;
    logic [7:0] fmt [5];
    logic [8:0] dat [5];
    logic [12:0] f;
    int k;
    fmt = '{8'h00, 8'h19, 8'h2E, 8'h13, 8'h44};
    dat = '{9'h1A5, 9'h0C3, 9'h15A, 9'h081, 9'h03C};
    for (int i = 0; i < 5; i++) begin
      @(negedge mclk);
      cfg = msi_cfg_t'(fmt[i]);
      brg_div = (i == 1) ? 16'h0001 : 16'h0000;
      f = frame(dat[i], cfg, 1'b0, 1'b0, k);
      n_after = 4'(k);
      rem.got_q.delete();
      put(dat[i]);
      wait_q(1);
      chk_word("tx frame", f, rem.got_q[0]);
      repeat (40) @(negedge mclk);
      chk_bit("tx end", 1'b1, irq.tx_end);
    end
  endtask
  task automatic t_b2b;
    logic [12:0] f, g;
    int k;
    @(negedge mclk);
    cfg = msi_cfg_t'(8'h19);
    f = frame(9'h0A5, cfg, 1'b0, 1'b0, k);
    g = frame(9'h05A, cfg, 1'b0, 1'b0, k);
    n_after = 4'(k);
    rem.got_q.delete();
    put(9'h0A5);
    put(9'h05A);
    chk_word("frames done", 13'h0000, 13'(rem.got_q.size()));
    chk_bit("tx empty", 1'b0, irq.tx_empty);
    wait_q(2);
    chk_word("first frame", f, rem.got_q[0]);
    chk_word("second frame", g, rem.got_q[1]);
    repeat (20) @(negedge mclk);
    chk_bit("tx end", 1'b1, irq.tx_end);
  endtask
  task automatic t_rx;
    logic [12:0] f;
    int k;
    for (int i = 0; i < 3; i++) begin
      f = frame(9'h0C5 + 9'(i), cfg, i == 1, i == 2, k);
      rem.send(f, k);
      take(9'h0C5 + 9'(i));
      chk_bit("parity err", i == 1, err.parity);
      chk_bit("framing err", i == 2, err.framing);
      chk_bit("rx err irq", i != 0, irq.rx_err);
      clr_err();
    end
  endtask
  task automatic t_ovr;
    logic [12:0] f;
    int k;
    for (int i = 0; i < 3; i++) begin
      f = frame(9'h030 + 9'(i), cfg, 1'b0, 1'b0, k);
      rem.send(f, k);
    end
    repeat (4) @(negedge mclk);
    chk_bit("overrun", 1'b1, err.overrun);
    take(9'h030);
    take(9'h031);
    chk_bit("rx drained", 1'b0, rx_valid);
    clr_err();
  endtask
  // One I2C byte; bits are taken where scl is released, the ack slot reads high
  task automatic i2c_byte(input logic [7:0] d);
    logic [12:0] got;
    logic prev;
    int n;
    got = '0;
    n = 0;
    prev = scl_oe;
    put({1'b0, d});
    repeat (200) begin
      @(negedge mclk);
      if (prev && !scl_oe) begin
        got = {got[11:0], sda_i};
        n++;
      end
      prev = scl_oe;
    end
    chk_word("i2c bits", {4'h0, d, 1'b1}, got);
    chk_word("i2c clocks", 13'h0009, 13'(n));
    chk_bit("scl held", 1'b1, scl_oe);
    take({1'b1, d});
  endtask
  // SPI byte; MOSI taken at each sck rise, MISO idles high so all ones return
  task automatic t_spi;
    logic [12:0] got;
    logic prev;
    int n;
    @(negedge mclk);
    cfg = msi_cfg_t'(8'hC1);
    got = '0;
    n = 0;
    prev = sck;
    put(9'h0B2);
    repeat (200) begin
      @(negedge mclk);
      if (sck && !prev) begin
        got = {got[11:0], txd};
        n++;
      end
      prev = sck;
    end
    chk_word("spi bits", 13'h00B2, got);
    chk_word("spi clocks", 13'h0008, 13'(n));
    chk_bit("sck rest", 1'b0, sck);
    take(9'h0FF);
    chk_bit("spi drained", 1'b0, rx_valid);
  endtask
  task automatic t_i2c;
    logic [2:0] got;
    int t;
    @(negedge mclk);
    cfg = msi_cfg_t'(8'h80);
    for (int i = 0; i < 3; i++) begin
      got = 3'h0;
      cond_kind = msi_cond_t'(i);
      cond_req = 1'b1;
      t = 0;
      while (cond_ready !== 1'b1 && t < 500) begin
        @(negedge mclk);
        t++;
      end
      @(negedge mclk);
      cond_req = 1'b0;
      repeat (60) begin
        @(negedge mclk);
        got = got | irq[2:0];
      end
      chk_word("cond event", 13'(3'h4 >> i), {10'h000, got});
      chk_bit("scl hold", i != 2, scl_oe);
      if (i != 2) i2c_byte(8'hA6 + 8'(i));
    end
    chk_bit("sda free", 1'b0, sda_oe);
  endtask
  // Whole run is under ten thousand cycles; this leaves ample margin
  initial begin
    repeat (40000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end
  initial begin
    reset_n = 1'b0;
    cfg = '0;
    brg_div = 16'h0000;
    tx_valid = 1'b0;
    tx_data = 9'h000;
    rx_ready = 1'b0;
    err_clr = '0;
    cond_req = 1'b0;
    cond_kind = COND_START;
    n_after = 4'h9;
    fail_count = 0;
    num_checks = 0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    t_reset();
    t_tx();
    t_b2b();
    t_rx();
    t_ovr();
    t_i2c();
    t_spi();
    print_verdict();
  end
endmodule
`default_nettype wire
